//--- rtl/sks_exec.sv
`timescale 1ns/1ps
// Notes on behaviour
// - decrement memory byte, skip when it reaches zero
// - accumulator gets byte minus one, skip if zero
// - a taken skip adds one dummy cycle
// - byte set writes all ones, flags kept
// - bit set forces one chosen bit only
// - increment memory byte, skip when it wraps
// - accumulator gets byte plus one, skip if zero
// - skip when the chosen bit is one
// - accumulator minus byte into accumulator, four flags
// - accumulator minus byte into memory, four flags
// - accumulator minus literal into accumulator, four flags
// - borrow bit clear on negative, else set
// - swap nibbles in place, flags kept
// - swapped byte into accumulator, memory kept
// - rewrite byte unchanged, skip when it is zero
// - copy byte to accumulator, skip if zero
// - skip when the chosen bit is zero
// - paged table read into memory and high byte
// - last page table read into memory and high byte
// - xor byte into accumulator, null flag only
// - xor result into memory, null flag only
// - xor literal into accumulator, null flag only
module sks_exec
    import sks_pkg::*;
#(
    parameter int PMEM_AW = SKS_PMEM_AW,
    parameter int PMEM_DW = SKS_PMEM_DW
)
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset_n,
    // Instruction issue from the fetch stage.
    input wire logic instr_valid,
    output logic instr_ready,
    input wire sks_pkg::sks_op_t instr_op,
    input wire logic [7:0] instr_addr,
    input wire logic [2:0] instr_bit,
    input wire logic [7:0] instr_lit,
    input wire logic [PMEM_AW-9:0] cur_page,
    output logic instr_done,
    output logic skip_next,
    output logic dummy_cycle,
    // Data memory, one cycle read latency.
    output logic [7:0] dmem_addr,
    input wire logic [7:0] dmem_rdata,
    output logic [7:0] dmem_wdata,
    output logic dmem_we,
    // Program memory, one cycle read latency.
    output logic [PMEM_AW-1:0] pmem_addr,
    input wire logic [PMEM_DW-1:0] pmem_rdata,
    // AXI4-Lite slave.
    input wire logic [SKS_AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [SKS_AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import sks_pkg::*;

    localparam int PAGE_W = PMEM_AW - 8;

    typedef enum {SKS_IDLE, SKS_READ, SKS_EXEC, SKS_DUMMY} sks_state_t;

    logic rst_meta_reg;
    logic rst_n;
    sks_state_t state_reg;
    sks_op_t op_reg;
    logic [7:0] lit_reg;
    logic [2:0] bit_reg;
    logic [7:0] dmem_addr_reg;
    logic [PMEM_AW-1:0] pmem_addr_reg;
    logic [7:0] acc_reg;
    logic [3:0] status_reg;
    logic [7:0] table_pointer_low_reg;
    logic [PAGE_W-1:0] table_pointer_high_reg;
    logic [7:0] table_high_byte_reg_reg;
    logic ctrl_reg;
    logic last_skip_reg;
    logic [7:0] wdata_out_reg;
    logic we_out_reg;
    logic done_reg;
    logic skip_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [SKS_AXI_AW-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic [7:0] alu_acc;
    logic alu_acc_we;
    logic [7:0] alu_mem;
    logic alu_mem_we;
    logic [3:0] alu_flags;
    logic alu_skip;

    // Reset is asserted at once and released through two flip-flops.
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // Table address: the high pointer is optional, the last page is all ones.
    wire take = instr_valid && instr_ready;
    wire is_exec = state_reg == SKS_EXEC;
    wire is_table = (op_reg == SKS_OP_TAB_PAGED) || (op_reg == SKS_OP_TAB_LAST);
    wire [PAGE_W-1:0] page_sel = ctrl_reg ? table_pointer_high_reg : cur_page;
    wire [PMEM_AW-1:0] tab_addr = (instr_op == SKS_OP_TAB_LAST) ?
        {{PAGE_W{1'b1}}, table_pointer_low_reg} : {page_sel, table_pointer_low_reg};
    wire exec_mem_we = is_exec && (alu_mem_we || is_table);
    wire [7:0] exec_mem_val = is_table ? pmem_rdata[7:0] : alu_mem;

    assign instr_ready = state_reg == SKS_IDLE;
    assign dummy_cycle = state_reg == SKS_DUMMY;
    assign instr_done = done_reg;
    assign skip_next = skip_reg;
    assign dmem_addr = dmem_addr_reg;
    assign dmem_wdata = wdata_out_reg;
    assign dmem_we = we_out_reg;
    assign pmem_addr = pmem_addr_reg;

    sks_alu u_alu (
        .op(op_reg),
        .acc(acc_reg),
        .mem(dmem_rdata),
        .lit(lit_reg),
        .bit_sel(bit_reg),
        .flags(status_reg),
        .acc_next(alu_acc),
        .acc_we(alu_acc_we),
        .mem_next(alu_mem),
        .mem_we(alu_mem_we),
        .flags_next(alu_flags),
        .skip(alu_skip)
    );

    // Read, execute, then a dummy cycle only when the skip is taken.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= SKS_IDLE;
        else
            case (state_reg)
                SKS_IDLE: state_reg <= take ? SKS_READ : SKS_IDLE;
                SKS_READ: state_reg <= SKS_EXEC;
                SKS_EXEC: state_reg <= alu_skip ? SKS_DUMMY : SKS_IDLE;
                SKS_DUMMY: state_reg <= SKS_IDLE;
                default: state_reg <= SKS_IDLE;
            endcase
    end

    // Operands are captured at issue so the fetch stage may move on.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_reg <= SKS_OP_SET_BYTE;
            lit_reg <= SKS_BYTE_NULL;
            bit_reg <= 3'h0;
            dmem_addr_reg <= SKS_BYTE_NULL;
            pmem_addr_reg <= '0;
        end
        else if (take)
        begin
            op_reg <= instr_op;
            lit_reg <= instr_lit;
            bit_reg <= instr_bit;
            dmem_addr_reg <= instr_addr;
            pmem_addr_reg <= tab_addr;
        end
    end

    // Memory write, completion and skip leave through flip-flops.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wdata_out_reg <= SKS_BYTE_NULL;
            we_out_reg <= 1'b0;
            done_reg <= 1'b0;
            skip_reg <= 1'b0;
        end
        else
        begin
            wdata_out_reg <= exec_mem_val;
            we_out_reg <= exec_mem_we;
            done_reg <= is_exec;
            skip_reg <= is_exec && alu_skip;
        end
    end

    // AXI write decode; the core wins over software on the same cycle.
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire wr_go = (aw_held_reg || aw_hs) && (w_held_reg || w_hs);
    wire [SKS_AXI_AW-1:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
    wire [3:0] wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
    wire wr_lo = wr_go && wr_strb[0];
    wire wr_acc = wr_lo && (wr_addr == SKS_OFS_ACC);
    wire wr_status = wr_lo && (wr_addr == SKS_OFS_STATUS);
    wire wr_table_pointer_low = wr_lo && (wr_addr == SKS_OFS_TABLE_POINTER_LOW);
    wire wr_table_pointer_high = wr_lo && (wr_addr == SKS_OFS_TABLE_POINTER_HIGH);
    wire wr_ctrl = wr_lo && (wr_addr == SKS_OFS_CTRL);
    wire wr_known = (wr_addr == SKS_OFS_ACC) || (wr_addr == SKS_OFS_STATUS) ||
        (wr_addr == SKS_OFS_TABLE_POINTER_LOW) || (wr_addr == SKS_OFS_TABLE_POINTER_HIGH) ||
        (wr_addr == SKS_OFS_TABLE_HIGH_BYTE_REG) || (wr_addr == SKS_OFS_CTRL) || (wr_addr == SKS_OFS_INFO);

    // Architectural registers.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_reg <= SKS_ACC_RST;
            status_reg <= SKS_STATUS_RST;
            table_pointer_low_reg <= SKS_BYTE_NULL;
            table_pointer_high_reg <= '0;
            table_high_byte_reg_reg <= SKS_BYTE_NULL;
            ctrl_reg <= SKS_CTRL_RST;
            last_skip_reg <= 1'b0;
        end
        else
        begin
            if (is_exec && alu_acc_we)
                acc_reg <= alu_acc;
            else if (wr_acc)
                acc_reg <= wr_data[7:0];
            if (is_exec)
                status_reg <= alu_flags;
            else if (wr_status)
                status_reg <= wr_data[SKS_ST_W-1:0];
            if (wr_table_pointer_low)
                table_pointer_low_reg <= wr_data[7:0];
            if (wr_table_pointer_high)
                table_pointer_high_reg <= wr_data[PAGE_W-1:0];
            if (wr_ctrl)
                ctrl_reg <= wr_data[SKS_CTRL_HIPTR];
            if (is_exec && is_table)
                table_high_byte_reg_reg <= pmem_rdata[15:8];
            if (is_exec)
                last_skip_reg <= alu_skip;
        end
    end

    // Write channel holding and response.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= SKS_RESP_OKAY;
        end
        else
        begin
            if (aw_hs)
                awaddr_reg <= s_axi_awaddr;
            if (w_hs)
            begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            aw_held_reg <= wr_go ? 1'b0 : (aw_held_reg || aw_hs);
            w_held_reg <= wr_go ? 1'b0 : (w_held_reg || w_hs);
            if (wr_go)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_known ? SKS_RESP_OKAY : SKS_RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // Read decode; an unmapped address answers zero with an error.
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire [1:0] info_val = {last_skip_reg, state_reg != SKS_IDLE};
    logic [31:0] rd_mux;
    logic rd_known;
    always_comb
    begin
        rd_mux = 32'h0;
        rd_known = 1'b1;
        case (s_axi_araddr)
            SKS_OFS_ACC: rd_mux[7:0] = acc_reg;
            SKS_OFS_STATUS: rd_mux[SKS_ST_W-1:0] = status_reg;
            SKS_OFS_TABLE_POINTER_LOW: rd_mux[7:0] = table_pointer_low_reg;
            SKS_OFS_TABLE_POINTER_HIGH: rd_mux[PAGE_W-1:0] = table_pointer_high_reg;
            SKS_OFS_TABLE_HIGH_BYTE_REG: rd_mux[7:0] = table_high_byte_reg_reg;
            SKS_OFS_CTRL: rd_mux[SKS_CTRL_HIPTR] = ctrl_reg;
            SKS_OFS_INFO: rd_mux[SKS_INFO_SKIP:SKS_INFO_BUSY] = info_val;
            default: rd_known = 1'b0;
        endcase
    end

    // Read data is registered one cycle after the address is taken.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= SKS_RESP_OKAY;
        end
        else if (ar_hs)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_known ? SKS_RESP_OKAY : SKS_RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // Checks on the execution sequence.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_skip_dummy: assert property (skip_next |-> dummy_cycle ##1 instr_ready)
        else $error("taken skip did not insert exactly one dummy cycle");
    a_noskip_single: assert property (instr_done && !skip_next |-> instr_ready)
        else $error("untaken skip stalled issue");
    a_issue_done: assert property (take |-> ##3 instr_done)
        else $error("instruction did not complete three cycles after issue");
    a_byte_set: assert property (is_exec && op_reg == SKS_OP_SET_BYTE
        |=> dmem_we && dmem_wdata == SKS_BYTE_ONES && $stable(status_reg))
        else $error("byte set wrong value or flags moved");
    a_bit_set: assert property (is_exec && op_reg == SKS_OP_SET_BIT
        |=> dmem_wdata == ($past(dmem_rdata) | (8'h01 << $past(bit_reg))))
        else $error("bit set touched other bits");
    a_sub_borrow: assert property (is_exec && op_reg == SKS_OP_SUB_ACC
        |=> status_reg[SKS_ST_C] == ($past(acc_reg) >= $past(dmem_rdata)))
        else $error("borrow bit wrong after subtract");
    a_xor_flags: assert property (is_exec && op_reg == SKS_OP_XOR_MEM
        |=> status_reg[SKS_ST_C] == $past(status_reg[SKS_ST_C])
        && status_reg[SKS_ST_Z] == (dmem_wdata == SKS_BYTE_NULL))
        else $error("xor to memory flag update wrong");
    a_swap_acc: assert property (is_exec && op_reg == SKS_OP_SWAP_ACC
        |=> acc_reg == sks_swap($past(dmem_rdata)) && !dmem_we)
        else $error("swap to accumulator wrong");
    a_table_high: assert property (is_exec && is_table
        |=> table_high_byte_reg_reg == $past(pmem_rdata[15:8]) && dmem_we)
        else $error("table read high byte lost");
    a_dec_skip: assert property (is_exec && op_reg == SKS_OP_DEC_SKIP
        |=> skip_next == (dmem_wdata == SKS_BYTE_NULL))
        else $error("decrement skip decision wrong");

    c_skip_taken: cover property (take ##3 skip_next ##1 instr_ready);
    c_sub_neg: cover property (is_exec && op_reg == SKS_OP_SUB_IMM && alu_acc[7]);
    c_table_last: cover property (is_exec && op_reg == SKS_OP_TAB_LAST);
    c_axi_write: cover property (wr_go && aw_hs && w_hs);

endmodule

//--- pkg/sks_pkg.sv
package sks_pkg;

    // Datapath and memory geometry.
    localparam int SKS_DATA_W = 8;
    localparam int SKS_PMEM_AW = 12;
    localparam int SKS_PMEM_DW = 16;
    localparam int SKS_AXI_AW = 8;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] SKS_OFS_ACC = 8'h00;
    localparam logic [7:0] SKS_OFS_STATUS = 8'h04;
    localparam logic [7:0] SKS_OFS_TABLE_POINTER_LOW = 8'h08;
    localparam logic [7:0] SKS_OFS_TABLE_POINTER_HIGH = 8'h0c;
    localparam logic [7:0] SKS_OFS_TABLE_HIGH_BYTE_REG = 8'h10;
    localparam logic [7:0] SKS_OFS_CTRL = 8'h14;
    localparam logic [7:0] SKS_OFS_INFO = 8'h18;

    // Status field positions: borrow_inverse_bit, half_borrow_flag, result_null, excess.
    localparam int SKS_ST_C = 0;
    localparam int SKS_ST_AC = 1;
    localparam int SKS_ST_Z = 2;
    localparam int SKS_ST_OV = 3;
    localparam int SKS_ST_W = 4;

    // Control and information field positions.
    localparam int SKS_CTRL_HIPTR = 0;
    localparam int SKS_INFO_BUSY = 0;
    localparam int SKS_INFO_SKIP = 1;

    // Reset values and fixed patterns.
    localparam logic [7:0] SKS_ACC_RST = 8'h00;
    localparam logic [3:0] SKS_STATUS_RST = 4'h0;
    localparam logic SKS_CTRL_RST = 1'b1;
    localparam logic [7:0] SKS_BYTE_ONES = 8'hff;
    localparam logic [7:0] SKS_BYTE_NULL = 8'h00;
    localparam logic [1:0] SKS_RESP_OKAY = 2'b00;
    localparam logic [1:0] SKS_RESP_SLVERR = 2'b10;

    // Instructions handled by this execution unit.
    typedef enum logic [4:0] {
        SKS_OP_DEC_SKIP, SKS_OP_DEC_SKIP_ACC, SKS_OP_SET_BYTE, SKS_OP_SET_BIT,
        SKS_OP_INC_SKIP, SKS_OP_INC_SKIP_ACC, SKS_OP_SKIP_BIT_SET, SKS_OP_SUB_ACC,
        SKS_OP_SUB_MEM, SKS_OP_SUB_IMM, SKS_OP_SWAP_MEM, SKS_OP_SWAP_ACC,
        SKS_OP_SKIP_NULL, SKS_OP_SKIP_NULL_ACC, SKS_OP_SKIP_BIT_CLR,
        SKS_OP_TAB_PAGED, SKS_OP_TAB_LAST, SKS_OP_XOR_ACC, SKS_OP_XOR_MEM, SKS_OP_XOR_IMM
    } sks_op_t;

    // Exchanges the two nibbles of a byte.
    function automatic logic [7:0] sks_swap(input logic [7:0] v);
        sks_swap = {v[3:0], v[7:4]};
    endfunction

endpackage

//--- rtl/sks_alu.sv
`timescale 1ns/1ps
module sks_alu
    import sks_pkg::*;
(
    // Instruction and operands.
    input wire sks_pkg::sks_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] mem,
    input wire logic [7:0] lit,
    input wire logic [2:0] bit_sel,
    input wire logic [3:0] flags,
    // Results.
    output logic [7:0] acc_next,
    output logic acc_we,
    output logic [7:0] mem_next,
    output logic mem_we,
    output logic [3:0] flags_next,
    output logic skip
);
    import sks_pkg::*;

    logic [7:0] sub_b;
    logic [8:0] diff;
    logic [3:0] sub_flags;
    logic [7:0] dec_v;
    logic [7:0] inc_v;
    logic [7:0] xor_b;
    logic [7:0] xor_v;
    logic bit_v;

    // Shared operand selection and arithmetic.
    assign sub_b = (op == SKS_OP_SUB_IMM) ? lit : mem;
    assign diff = {1'b0, acc} - {1'b0, sub_b};
    assign dec_v = mem - 8'h01;
    assign inc_v = mem + 8'h01;
    assign xor_b = (op == SKS_OP_XOR_IMM) ? lit : mem;
    assign xor_v = acc ^ xor_b;
    assign bit_v = mem[bit_sel];

    // Signed overflow, inverted half borrow, null and inverted borrow.
    assign sub_flags[SKS_ST_OV] = (acc[7] != sub_b[7]) && (diff[7] != acc[7]);
    assign sub_flags[SKS_ST_AC] = acc[3:0] >= sub_b[3:0];
    assign sub_flags[SKS_ST_Z] = diff[7:0] == SKS_BYTE_NULL;
    assign sub_flags[SKS_ST_C] = ~diff[8];

    // Flags are held unless an operation names them.
    always_comb
    begin
        acc_next = acc;
        acc_we = 1'b0;
        mem_next = mem;
        mem_we = 1'b0;
        flags_next = flags;
        skip = 1'b0;
        case (op)
            SKS_OP_DEC_SKIP:
            begin
                mem_next = dec_v;
                mem_we = 1'b1;
                skip = dec_v == SKS_BYTE_NULL;
            end
            SKS_OP_DEC_SKIP_ACC:
            begin
                acc_next = dec_v;
                acc_we = 1'b1;
                skip = dec_v == SKS_BYTE_NULL;
            end
            SKS_OP_SET_BYTE:
            begin
                mem_next = SKS_BYTE_ONES;
                mem_we = 1'b1;
            end
            SKS_OP_SET_BIT:
            begin
                mem_next[bit_sel] = 1'b1;
                mem_we = 1'b1;
            end
            SKS_OP_INC_SKIP:
            begin
                mem_next = inc_v;
                mem_we = 1'b1;
                skip = inc_v == SKS_BYTE_NULL;
            end
            SKS_OP_INC_SKIP_ACC:
            begin
                acc_next = inc_v;
                acc_we = 1'b1;
                skip = inc_v == SKS_BYTE_NULL;
            end
            SKS_OP_SKIP_BIT_SET: skip = bit_v;
            SKS_OP_SUB_ACC, SKS_OP_SUB_IMM:
            begin
                acc_next = diff[7:0];
                acc_we = 1'b1;
                flags_next = sub_flags;
            end
            SKS_OP_SUB_MEM:
            begin
                mem_next = diff[7:0];
                mem_we = 1'b1;
                flags_next = sub_flags;
            end
            SKS_OP_SWAP_MEM:
            begin
                mem_next = sks_swap(mem);
                mem_we = 1'b1;
            end
            SKS_OP_SWAP_ACC:
            begin
                acc_next = sks_swap(mem);
                acc_we = 1'b1;
            end
            SKS_OP_SKIP_NULL:
            begin
                mem_we = 1'b1;
                skip = mem == SKS_BYTE_NULL;
            end
            SKS_OP_SKIP_NULL_ACC:
            begin
                acc_next = mem;
                acc_we = 1'b1;
                skip = mem == SKS_BYTE_NULL;
            end
            SKS_OP_SKIP_BIT_CLR: skip = ~bit_v;
            SKS_OP_XOR_ACC, SKS_OP_XOR_IMM:
            begin
                acc_next = xor_v;
                acc_we = 1'b1;
                flags_next[SKS_ST_Z] = xor_v == SKS_BYTE_NULL;
            end
            SKS_OP_XOR_MEM:
            begin
                mem_next = xor_v;
                mem_we = 1'b1;
                flags_next[SKS_ST_Z] = xor_v == SKS_BYTE_NULL;
            end
            default:
            begin
                acc_we = 1'b0;
            end
        endcase
    end

endmodule

//--- verification/sks_mem_model.sv
`timescale 1ns/1ps
// Data and program memory beside the execution unit, both read one cycle after the address.
module sks_mem_model
    import sks_pkg::*;
(
    // Clock.
    input wire logic mclk,
    // Data memory port.
    input wire logic [7:0] dmem_addr,
    output logic [7:0] dmem_rdata,
    input wire logic [7:0] dmem_wdata,
    input wire logic dmem_we,
    // Program memory port.
    input wire logic [SKS_PMEM_AW-1:0] pmem_addr,
    output logic [SKS_PMEM_DW-1:0] pmem_rdata
);
    logic [7:0] dmem [256];
    // Each program word carries its own address bits, so a wrong page or swapped half shows.
    // A plain process, since the bench also presets this array between edges.
    always @(posedge mclk)
    begin
        if (dmem_we)
            dmem[dmem_addr] <= dmem_wdata;
        dmem_rdata <= dmem[dmem_addr];
        pmem_rdata <= {4'h5, pmem_addr[11:8], pmem_addr[7:0] ^ 8'h3c};
    end
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
    import sks_pkg::*;
    // Case word nibbles: bit, memory, acc, literal, expected memory, acc, status, skip.
    typedef struct {sks_op_t o; logic [51:0] v;} sks_case_t;
    // Inputs start idle; address, page, strobe and both response readies never change.
    logic mclk = 1'b0, reset_n = 1'b0, instr_valid = 1'b0, s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b1, s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
    sks_op_t instr_op = SKS_OP_SET_BYTE;
    logic [7:0] instr_addr = 8'h20, instr_lit = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] instr_bit = 3'h0;
    logic [3:0] cur_page = 4'h6, s_axi_wstrb = 4'h1;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic instr_ready, instr_done, skip_next, dmem_we, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, dummy_cycle;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [7:0] dmem_addr, dmem_rdata, dmem_wdata;
    logic [11:0] pmem_addr;
    logic [15:0] pmem_rdata;
    int mismatches = 0, n_tests = 0, cyc = 0;
    // Status preset is 4'ha so that kept flags and changed flags both show.
    sks_case_t tv [21] = '{
        '{SKS_OP_DEC_SKIP, 52'h0_01_55_00_00_55_a_1},
        '{SKS_OP_DEC_SKIP_ACC, 52'h0_01_55_00_01_00_a_1},
        '{SKS_OP_SET_BYTE, 52'h0_12_55_00_ff_55_a_0},
        '{SKS_OP_SET_BIT, 52'h7_01_55_00_81_55_a_0},
        '{SKS_OP_INC_SKIP, 52'h0_ff_55_00_00_55_a_1},
        '{SKS_OP_INC_SKIP_ACC, 52'h0_fe_55_00_fe_ff_a_0},
        '{SKS_OP_SKIP_BIT_SET, 52'h3_08_55_00_08_55_a_1},
        '{SKS_OP_SKIP_BIT_SET, 52'h3_f7_55_00_f7_55_a_0},
        '{SKS_OP_SUB_ACC, 52'h0_07_05_00_07_fe_0_0},
        '{SKS_OP_SUB_MEM, 52'h0_01_80_00_7f_80_9_0},
        '{SKS_OP_SUB_IMM, 52'h0_00_33_33_00_00_7_0},
        '{SKS_OP_SWAP_MEM, 52'h0_a5_55_00_5a_55_a_0},
        '{SKS_OP_SWAP_ACC, 52'h0_c3_55_00_c3_3c_a_0},
        '{SKS_OP_SKIP_NULL, 52'h0_00_55_00_00_55_a_1},
        '{SKS_OP_SKIP_NULL_ACC, 52'h0_00_77_00_00_00_a_1},
        '{SKS_OP_SKIP_BIT_CLR, 52'h0_fe_55_00_fe_55_a_1},
        '{SKS_OP_XOR_ACC, 52'h0_0f_0f_00_0f_00_e_0},
        '{SKS_OP_XOR_MEM, 52'h0_0f_f0_00_ff_f0_a_0},
        '{SKS_OP_XOR_IMM, 52'h0_00_aa_aa_00_00_e_0},
        '{SKS_OP_TAB_PAGED, 52'h0_00_55_00_1d_55_a_0},
        '{SKS_OP_TAB_LAST, 52'h0_00_55_00_1d_55_a_0}
    };
    sks_exec dut (.mclk, .reset_n, .instr_valid, .instr_ready, .instr_op, .instr_addr, .instr_bit,
        .instr_lit, .cur_page, .instr_done, .skip_next, .dummy_cycle, .dmem_addr, .dmem_rdata,
        .dmem_wdata, .dmem_we, .pmem_addr, .pmem_rdata, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    sks_mem_model mem (.mclk, .dmem_addr, .dmem_rdata, .dmem_wdata, .dmem_we, .pmem_addr,
        .pmem_rdata);
    // 40 MHz clock; a hang is cut short long after every test should have ended.
    initial forever #12.5 mclk = ~mclk;
    always @(posedge mclk) if (++cyc == 4000) give_verdict();
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // Address and data go out together, so the slave takes both at the same edge.
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        s_axi_awaddr <= ad;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(negedge mclk); while (!(s_axi_awready && s_axi_wready));
        @(posedge mclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(negedge mclk); while (s_axi_bvalid !== 1'b1);
        rr = s_axi_bresp;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] ad);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        do @(negedge mclk); while (s_axi_arready !== 1'b1);
        @(posedge mclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge mclk); while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        @(posedge mclk);
    endtask
    // Memory is preset between edges so the model never races its own read.
    task automatic run(input sks_case_t c);
        logic mw;
        @(negedge mclk);
        mem.dmem[8'h20] = c.v[47:40];
        @(posedge mclk);
        wr(SKS_OFS_ACC, c.v[39:32]);
        wr(SKS_OFS_STATUS, 8'h0a);
        instr_op <= c.o;
        instr_bit <= c.v[50:48];
        instr_lit <= c.v[31:24];
        instr_valid <= 1'b1;
        do @(negedge mclk); while (instr_ready !== 1'b1);
        @(posedge mclk);
        instr_valid <= 1'b0;
        repeat (3) @(negedge mclk);
        // Only the forms that own a memory result may pulse the write strobe.
        mw = c.o inside {SKS_OP_DEC_SKIP, SKS_OP_SET_BYTE, SKS_OP_SET_BIT, SKS_OP_INC_SKIP,
            SKS_OP_SUB_MEM, SKS_OP_SWAP_MEM, SKS_OP_SKIP_NULL, SKS_OP_XOR_MEM, SKS_OP_TAB_PAGED,
            SKS_OP_TAB_LAST};
        chk(instr_done, 1'b1);
        chk(dmem_we, mw);
        chk(dummy_cycle, c.v[0]);
        chk(skip_next, c.v[0]);
        chk(instr_ready, !c.v[0]);
        @(posedge mclk);
        rd(SKS_OFS_ACC);
        chk(rv, c.v[15:8]);
        rd(SKS_OFS_STATUS);
        chk(rv, c.v[7:4]);
        rd(SKS_OFS_INFO);
        chk(rv, {30'h0, c.v[0], 1'b0});
        chk(mem.dmem[8'h20], c.v[23:16]);
    endtask
    task automatic give_verdict();
        if (cyc >= 4000)
            mismatches++;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence: reset, register checks, then every instruction kind.
    initial
    begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(SKS_OFS_CTRL);
        chk(rv, 32'h1);
        rd(8'h40);
        chk(rr, SKS_RESP_SLVERR);
        $display("test registers done");
        wr(SKS_OFS_TABLE_POINTER_LOW, 8'h21);
        wr(SKS_OFS_TABLE_POINTER_HIGH, 8'h03);
        chk(rr, SKS_RESP_OKAY);
        wr(8'h40, 8'h00);
        chk(rr, SKS_RESP_SLVERR);
        for (int i = 0; i < 20; i++)
            run(tv[i]);
        rd(SKS_OFS_TABLE_HIGH_BYTE_REG);
        chk(rv, 32'h53);
        run(tv[20]);
        rd(SKS_OFS_TABLE_HIGH_BYTE_REG);
        chk(rv, 32'h5f);
        wr(SKS_OFS_CTRL, 8'h00);
        run(tv[19]);
        rd(SKS_OFS_TABLE_HIGH_BYTE_REG);
        chk(rv, 32'h56);
        $display("test instructions done");
        give_verdict();
    end
endmodule
